// ---- src/lgfr_top.sv ----
// How it works
// RULE1 - Lane byte bits 6:4 equalizer, reset zero
// RULE2 - Lane byte bits 3:2 flat gain, reset 10
// RULE3 - Lane bits 7,1,0 reserved, writable, reset zero
// RULE4 - Flip byte bit1 crosses sideband pairs
// RULE5 - Flip byte bit0 swaps all four lanes
// RULE6 - Software keeps reserved bits at power-up values
`timescale 1ns/1ps
`include "lgfr_consts.svh"

module lgfr_top (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  output lgfr_pkg::lgfr_cfg_t CFG
);

  lgfr_pkg::lgfr_bus_t q;
  lgfr_pkg::lgfr_bus_t d;
  logic [7:0] regs [`LGFR_NUM_REGS];
  logic [7:0] rdata;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  localparam logic [7:0] OFFSETS [`LGFR_NUM_REGS] = '{`LGFR_OFS_LANE0, `LGFR_OFS_LANE1,
    `LGFR_OFS_LANE2, `LGFR_OFS_LANE3, `LGFR_OFS_FLIP, `LGFR_OFS_RSVD_A};

  genvar gi;
  generate
    for (gi = 0; gi < `LGFR_NUM_REGS; gi++) begin : g_reg
      lgfr_byte_reg #(
        .RESET_VAL(gi < 4 ? `LGFR_RST_LANE : (gi == 4 ? `LGFR_RST_FLIP : `LGFR_RST_RSVD_A)),
        .OFFSET(OFFSETS[gi])
      ) u_reg (
        .clk(CLK_SYS),
        .rst_n(RESET_N),
        .we(q.wr),
        .waddr(q.waddr),
        .wdata(q.wdata),
        .q_out(regs[gi])
      );
    end
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign CFG.lane[gi].equalizer_code = regs[gi][`LGFR_EQ_MSB:`LGFR_EQ_LSB]; // [RULE1]
      assign CFG.lane[gi].flat_gain_code = regs[gi][`LGFR_FG_MSB:`LGFR_FG_LSB]; // [RULE2]
    end
  endgenerate

  assign CFG.sideband_pair_cross = regs[4][`LGFR_AUX_BIT]; // [RULE4]
  assign CFG.displayport_lane_swap = regs[4][`LGFR_SWAP_BIT]; // [RULE5]

  // Whole bytes read back, reserved bits as stored; unmapped offsets read zero
  always_comb begin
    rdata = 8'h00;
    case (q.ptr)
      `LGFR_OFS_LANE0: rdata = regs[0]; // [RULE3]
      `LGFR_OFS_LANE1: rdata = regs[1];
      `LGFR_OFS_LANE2: rdata = regs[2];
      `LGFR_OFS_LANE3: rdata = regs[3];
      `LGFR_OFS_FLIP: rdata = regs[4];
      `LGFR_OFS_RSVD_A: rdata = regs[5];
      default: rdata = 8'h00;
    endcase
  end

  // Pins are synchronous, so one stage of history is enough for edges
  assign scl_rise = !q.scl && SCL_IN;
  assign scl_fall = q.scl && !SCL_IN;
  assign start_cond = q.scl && SCL_IN && q.sda && !SDA_IN;
  assign stop_cond = q.scl && SCL_IN && !q.sda && SDA_IN;

  always_comb begin
    d = q;
    d.wr = 1'b0;
    d.scl = SCL_IN;
    d.sda = SDA_IN;
    d.sda_out = 1'b0;
    if (start_cond) begin
      d.st = lgfr_pkg::ST_ADDR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
    end else if (stop_cond) begin
      d.st = lgfr_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        lgfr_pkg::ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        lgfr_pkg::ST_ADDR, lgfr_pkg::ST_WRITE: begin
          if (scl_rise && !q.cnt[3]) begin
            d.sr = {q.sr[6:0], SDA_IN};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt[3]) begin
            d.cnt = 4'h0;
            if (q.st == lgfr_pkg::ST_ADDR) begin
              if (q.sr[7:1] == `LGFR_SLAVE_ADDR) begin
                d.rw = q.sr[0];
                d.ptr_phase = 1'b1;
                d.st = lgfr_pkg::ST_ACK;
                d.sda_oe = 1'b1;
              end else begin
                d.st = lgfr_pkg::ST_IDLE;
              end
            end else begin
              d.st = lgfr_pkg::ST_ACK;
              d.sda_oe = 1'b1;
              if (q.ptr_phase) begin
                d.ptr = q.sr;
                d.ptr_phase = 1'b0;
              end else begin
                // Write strobe reaches the byte registers one cycle later
                d.wr = 1'b1; // [RULE3]
                d.waddr = q.ptr;
                d.wdata = q.sr;
                d.ptr = q.ptr + 8'h01;
              end
            end
          end
        end
        lgfr_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.st = lgfr_pkg::ST_READ;
              d.sr = rdata;
              d.sda_oe = !rdata[7];
              d.cnt = 4'h1;
              d.ptr = q.ptr + 8'h01;
            end else begin
              d.st = lgfr_pkg::ST_WRITE;
              d.sda_oe = 1'b0;
            end
          end
        end
        lgfr_pkg::ST_READ: begin
          if (scl_fall) begin
            if (q.cnt[3]) begin
              d.sda_oe = 1'b0;
              d.st = lgfr_pkg::ST_RACK;
            end else begin
              d.sda_oe = !q.sr[3'h7 - q.cnt[2:0]];
              d.cnt = q.cnt + 4'h1;
            end
          end
        end
        lgfr_pkg::ST_RACK: begin
          if (scl_rise) begin
            d.nack = SDA_IN;
          end else if (scl_fall) begin
            if (q.nack) begin
              d.st = lgfr_pkg::ST_IDLE;
            end else begin
              d.st = lgfr_pkg::ST_READ;
              d.sr = rdata;
              d.sda_oe = !rdata[7];
              d.cnt = 4'h1;
              d.ptr = q.ptr + 8'h01;
            end
          end
        end
        default: begin
          d.st = lgfr_pkg::ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      q <= '{st: lgfr_pkg::ST_IDLE, scl: 1'b1, sda: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  assign SDA_OUT = q.sda_out;
  assign SDA_OE = q.sda_oe;

  a_lane_eq_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [RULE1]
    (q.wr && q.waddr == `LGFR_OFS_LANE2) |=> CFG.lane[2].equalizer_code == $past(q.wdata[6:4]))
    else $error("Equalizer code did not follow a write");

  a_lane_fg_write: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [RULE2]
    (q.wr && q.waddr == `LGFR_OFS_LANE0) |=> CFG.lane[0].flat_gain_code == $past(q.wdata[3:2]))
    else $error("Flat gain code did not follow a write");

  a_reset_defaults: assert property (@(posedge CLK_SYS) // [RULE2]
    !RESET_N |=> (CFG.lane[3].flat_gain_code == 2'b10 && CFG.lane[1].equalizer_code == 3'b000
    && regs[0] == 8'h08 && !CFG.sideband_pair_cross && !CFG.displayport_lane_swap))
    else $error("Lane or flip defaults wrong after reset");

  a_reserved_kept: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [RULE3]
    (q.wr && q.waddr == `LGFR_OFS_LANE1) |=> regs[1] == $past(q.wdata))
    else $error("Reserved lane bits not stored");

  a_aux_cross: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [RULE4]
    (q.wr && q.waddr == `LGFR_OFS_FLIP) |=> CFG.sideband_pair_cross == $past(q.wdata[1]))
    else $error("Sideband cross did not follow flip byte");

  a_lane_swap: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [RULE5]
    !(q.wr && q.waddr == `LGFR_OFS_FLIP) |=> $stable(CFG.displayport_lane_swap))
    else $error("Lane swap changed without a flip byte write");

  a_eq_reset_zero: assert property (@(posedge CLK_SYS) // [RULE1]
    !RESET_N |=> (CFG.lane[0].equalizer_code == 3'h0 && CFG.lane[2].equalizer_code == 3'h0
    && CFG.lane[3].equalizer_code == 3'h0))
    else $error("Equalizer code not zero after reset");

  a_reserved_reset: assert property (@(posedge CLK_SYS) // [RULE3]
    !RESET_N |=> (regs[2][7] == 1'b0 && regs[3][1:0] == 2'h0))
    else $error("Reserved lane bits not zero after reset");

  a_swap_follows: assert property (@(posedge CLK_SYS) disable iff (!RESET_N) // [RULE5]
    (q.wr && q.waddr == `LGFR_OFS_FLIP) |=> CFG.displayport_lane_swap == $past(q.wdata[0]))
    else $error("Lane swap did not follow flip byte");

endmodule : lgfr_top

// ---- src/lgfr_consts.svh ----
`ifndef LGFR_CONSTS_SVH
`define LGFR_CONSTS_SVH

// Register offsets on the serial register bus
`define LGFR_OFS_LANE0 8'h05
`define LGFR_OFS_LANE1 8'h06
`define LGFR_OFS_LANE2 8'h07
`define LGFR_OFS_LANE3 8'h08
`define LGFR_OFS_FLIP 8'h09
`define LGFR_OFS_RSVD_A 8'h0A
`define LGFR_NUM_REGS 6

// Power-up values
`define LGFR_RST_LANE 8'h08
`define LGFR_RST_FLIP 8'h60
`define LGFR_RST_RSVD_A 8'hFC

// Field positions
`define LGFR_EQ_MSB 6
`define LGFR_EQ_LSB 4
`define LGFR_FG_MSB 3
`define LGFR_FG_LSB 2
`define LGFR_AUX_BIT 1
`define LGFR_SWAP_BIT 0

// Serial bus slave address, value arbitrary
`define LGFR_SLAVE_ADDR 7'h2A

`endif

// ---- src/lgfr_pkg.sv ----
package lgfr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_WRITE = 3'b010,
    ST_ACK = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } lgfr_state_t;

  typedef struct packed {
    logic [2:0] equalizer_code;
    logic [1:0] flat_gain_code;
  } lgfr_lane_t;

  typedef struct packed {
    lgfr_lane_t [3:0] lane;
    logic sideband_pair_cross;
    logic displayport_lane_swap;
  } lgfr_cfg_t;

  typedef struct packed {
    lgfr_state_t st;
    logic [3:0] cnt;
    logic [7:0] sr;
    logic [7:0] ptr;
    logic rw;
    logic ptr_phase;
    logic nack;
    logic scl;
    logic sda;
    logic sda_oe;
    logic sda_out;
    logic wr;
    logic [7:0] waddr;
    logic [7:0] wdata;
  } lgfr_bus_t;

endpackage : lgfr_pkg

// ---- src/lgfr_byte_reg.sv ----
`timescale 1ns/1ps
`include "lgfr_consts.svh"

module lgfr_byte_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] OFFSET = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  output logic [7:0] q_out
);

  logic [7:0] d;
  logic [7:0] q;

  // All eight bits are writable, reserved ones included
  always_comb begin
    d = q;
    if (we && waddr == OFFSET) begin
      d = wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= RESET_VAL;
    end else begin
      q <= d;
    end
  end

  assign q_out = q;

endmodule : lgfr_byte_reg

// ---- verification/lgfr_host_model.sv ----
`timescale 1ns/1ps
module lgfr_host_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  // Length of the SCL high phase (SCL stays low for two of these); the bench stretches it to act as a slow host
  int half_cycles = 4;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic half();
    repeat (half_cycles) @(negedge clk);
  endtask : half
  // SDA moves only while SCL is low, so no stray START or STOP is made
  task automatic put_bit(input logic b, output logic got);
    sda_low = !b;
    half();
    scl = 1'b1;
    half();
    got = sda_wire;
    scl = 1'b0;
    half();
  endtask : put_bit
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i], g);
    end
    put_bit(1'b1, g);
    ack = !g;
  endtask : send_byte
  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      d[i] = g;
    end
    put_bit(last, g);
  endtask : recv_byte
  task automatic start();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
    half();
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
endmodule : lgfr_host_model

// ---- verification/test_lane_gain_and_flip_regs.sv ----
`timescale 1ns/1ps
`include "lgfr_consts.svh"
module test_lane_gain_and_flip_regs;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic scl;
  logic sda_low;
  logic sda_out;
  logic sda_oe;
  logic sda_wire;
  lgfr_pkg::lgfr_cfg_t cfg;
  int miscompares = 0;
  int tests_run = 0;
  logic a0, a1, a2;
  logic [7:0] rd;
  logic [7:0] rst_val [6] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h60, 8'hFC};
  // Reserved lane bits stay at their power-up zero in every value written
  logic [7:0] lane_val [4] = '{8'h78, 8'h24, 8'h5C, 8'h30};
  logic [7:0] burst_val [4] = '{8'h78, 8'h24, 8'h30, 8'h5C};
  always #2.5 clk_sys = !clk_sys;
  // Pull-up on SDA; either party may pull it low
  assign sda_wire = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  lgfr_top i_lgfr_top (.CLK_SYS(clk_sys), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CFG(cfg));
  lgfr_host_model i_lgfr_host_model (.clk(clk_sys), .sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low));
  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %02h seen %02h", what, exp, got);
    end
  endtask : check_byte
  task automatic check_cfg(input lgfr_pkg::lgfr_cfg_t exp);
    tests_run++;
    if (cfg !== exp) begin
      miscompares++;
      $display("FAIL cfg expected %h seen %h", exp, cfg);
    end
  endtask : check_cfg
  function automatic lgfr_pkg::lgfr_cfg_t exp_cfg(input logic [7:0] l [4], input logic [7:0] f);
    lgfr_pkg::lgfr_cfg_t e;
    for (int i = 0; i < 4; i++) begin
      e.lane[i].equalizer_code = l[i][6:4];
      e.lane[i].flat_gain_code = l[i][3:2];
    end
    e.sideband_pair_cross = f[1];
    e.displayport_lane_swap = f[0];
    return e;
  endfunction : exp_cfg
  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] data);
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR, 1'b0}, a0);
    i_lgfr_host_model.send_byte(ofs, a1);
    i_lgfr_host_model.send_byte(data, a2);
    i_lgfr_host_model.stop();
    check_byte("write acks", 8'h01, {7'h00, a0 & a1 & a2});
  endtask : reg_write
  task automatic reg_read(input logic [7:0] ofs, output logic [7:0] d);
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR, 1'b0}, a0);
    i_lgfr_host_model.send_byte(ofs, a1);
    i_lgfr_host_model.stop();
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR, 1'b1}, a2);
    i_lgfr_host_model.recv_byte(1'b1, d);
    i_lgfr_host_model.stop();
    check_byte("read acks", 8'h01, {7'h00, a0 & a1 & a2});
  endtask : reg_read
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  // Bounded run; a hang counts as a mismatch
  initial begin
    repeat (60000) @(posedge clk_sys);
    miscompares++;
    $display("FAIL watchdog expected finish seen hang");
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    check_cfg(exp_cfg('{8'h08, 8'h08, 8'h08, 8'h08}, 8'h60));
    for (int i = 0; i < 6; i++) begin
      reg_read(8'(5 + i), rd);
      check_byte("power-up byte", rst_val[i], rd);
    end
    $display("test power_up done");
    for (int i = 0; i < 4; i++) begin
      i_lgfr_host_model.half_cycles = 4 + 5 * (i % 2);
      reg_write(8'(5 + i), lane_val[i]);
    end
    check_cfg(exp_cfg(lane_val, 8'h60));
    for (int i = 0; i < 4; i++) begin
      reg_read(8'(5 + i), rd);
      check_byte("lane byte", lane_val[i], rd);
    end
    $display("test lanes done");
    for (int v = 0; v < 4; v++) begin
      reg_write(8'h09, 8'h60 | 8'(v));
      check_cfg(exp_cfg(lane_val, 8'h60 | 8'(v)));
      reg_read(8'h09, rd);
      check_byte("flip byte", 8'h60 | 8'(v), rd);
    end
    $display("test flip done");
    // A foreign address must be ignored and leave every setting alone
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR ^ 7'h01, 1'b0}, a0);
    i_lgfr_host_model.stop();
    check_byte("foreign ack", 8'h00, {7'h00, a0});
    check_cfg(exp_cfg(lane_val, 8'h63));
    $display("test foreign address done");
    // Burst write then burst read: the pointer advances per byte both ways
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR, 1'b0}, a0);
    i_lgfr_host_model.send_byte(8'h07, a1);
    i_lgfr_host_model.send_byte(burst_val[2], a2);
    a1 = a1 & a2;
    i_lgfr_host_model.send_byte(burst_val[3], a2);
    i_lgfr_host_model.stop();
    check_byte("burst write acks", 8'h01, {7'h00, a0 & a1 & a2});
    check_cfg(exp_cfg(burst_val, 8'h63));
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR, 1'b0}, a0);
    i_lgfr_host_model.send_byte(8'h07, a1);
    i_lgfr_host_model.stop();
    i_lgfr_host_model.start();
    i_lgfr_host_model.send_byte({`LGFR_SLAVE_ADDR, 1'b1}, a2);
    i_lgfr_host_model.recv_byte(1'b0, rd);
    check_byte("burst byte 0x07", burst_val[2], rd);
    i_lgfr_host_model.recv_byte(1'b1, rd);
    check_byte("burst byte 0x08", burst_val[3], rd);
    i_lgfr_host_model.stop();
    check_byte("burst read acks", 8'h01, {7'h00, a0 & a1 & a2});
    $display("test burst done");
    report_and_stop();
  end
endmodule : test_lane_gain_and_flip_regs
